// >>> include/sbp_drive_if.sv
// Carrier between port control and pad driver stage
`timescale 1ns/1ns
`default_nettype none
interface sbp_drive_if #(parameter int W = 6);
   logic [W-1:0] latch;
   logic [W-1:0] dir;
   logic [W-1:0] hold_in;
   logic [W-1:0] pad_out;
   logic [W-1:0] pad_oe;
   modport ctrl  (output latch, output dir, output hold_in,
                  input pad_out, input pad_oe);
   modport drive (input latch, input dir, input hold_in,
                  output pad_out, output pad_oe);
endinterface : sbp_drive_if
`default_nettype wire

// >>> include/sbp_pkg.sv
// Constants, types and helpers for the six-bit port with direction control
package sbp_pkg;

   localparam int          SBP_W      = 6;
   localparam int          SBP_AW     = 12;
   localparam int          SBP_ACFG_W = 3;

   // Register indices; byte address is four times the index
   localparam logic [7:0]  IDX_DATA   = 8'h05;
   localparam logic [7:0]  IDX_DIR    = 8'h85;
   localparam logic [7:0]  IDX_ACFG   = 8'h9F;
   localparam logic [7:0]  IDX_SET    = 8'h06;
   localparam logic [7:0]  IDX_CLR    = 8'h07;

   localparam logic [5:0]  LATCH_RST  = 6'h00;
   localparam logic [5:0]  DIR_RST    = 6'h3F;
   localparam logic [2:0]  ACFG_RST   = 3'h0;

   localparam int          OD_BIT     = 4;
   localparam int          VREF_BIT   = 3;
   localparam int          SS_BIT     = 5;
   localparam logic [5:0]  OD_MASK    = 6'h10;
   localparam logic [5:0]  SS_MASK    = 6'h20;
   localparam logic [5:0]  ANA_ALL    = 6'h2F;
   localparam logic [5:0]  ANA_LOW4   = 6'h0F;
   localparam logic [5:0]  ANA_LOW3   = 6'h0B;
   localparam logic [5:0]  ANA_NONE   = 6'h00;

   localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
   localparam logic [31:0] RD_ZERO       = 32'h0000_0000;

   typedef enum logic [2:0] {
      ACC_NONE, ACC_DATA, ACC_DIR, ACC_ACFG, ACC_SET, ACC_CLR
   } sbp_acc_t;

   function automatic sbp_acc_t sbp_decode(input logic [SBP_AW-1:0] a);
      sbp_acc_t k;
      k = ACC_NONE;
      if (a[1:0] == 2'h0) begin
         case (a[9:2])
            IDX_DATA: k = ACC_DATA;
            IDX_DIR:  k = ACC_DIR;
            IDX_ACFG: k = ACC_ACFG;
            IDX_SET:  k = ACC_SET;
            IDX_CLR:  k = ACC_CLR;
            default:  k = ACC_NONE;
         endcase
      end
      if (a[SBP_AW-1:10] != 2'h0) k = ACC_NONE;
      return k;
   endfunction : sbp_decode

   // Analog selection: low bit of odd codes below six adds the reference input
   function automatic logic [5:0] sbp_ana_mask(input logic [2:0] c);
      case (c[2:1])
         2'h0:    return ANA_ALL;
         2'h1:    return ANA_LOW4;
         2'h2:    return ANA_LOW3;
         default: return ANA_NONE;
      endcase
   endfunction : sbp_ana_mask

endpackage : sbp_pkg

// >>> rtl/sbp_pad_drive.sv
// Registered pad driver stage for the six-bit port
`timescale 1ns/1ns
`default_nettype none
module sbp_pad_drive
   import sbp_pkg::*;
(
   input  wire logic  hclk,
   input  wire logic  hresetn,
   sbp_drive_if.drive dif
);

   logic [SBP_W-1:0] next_out;
   logic [SBP_W-1:0] next_oe;

   always_comb begin
      // Open-drain bit only ever pulls low
      next_out = dif.latch & ~OD_MASK;
      next_oe  = ~dif.dir & ~dif.hold_in & ~(OD_MASK & dif.latch);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dif.pad_out <= LATCH_RST;
         dif.pad_oe  <= LATCH_RST;
      end else begin
         dif.pad_out <= next_out;
         dif.pad_oe  <= next_oe;
      end
   end

   chk_dir_hiz: assert property (@(posedge hclk) disable iff (!hresetn)
      ((dif.pad_oe & $past(dif.dir)) == 6'h00))
      else $error("pin driven while direction bit set");

   chk_drive_latch: assert property (@(posedge hclk)
      disable iff (!hresetn)
      (!dif.dir[0] && !dif.hold_in[0]) |=>
         (dif.pad_oe[0] && dif.pad_out[0] == $past(dif.latch[0])))
      else $error("output pin does not carry latch value");

   chk_open_drain: assert property (@(posedge hclk) disable iff (!hresetn)
      !dif.pad_out[OD_BIT] &&
         (!dif.pad_oe[OD_BIT] || !$past(dif.latch[OD_BIT])))
      else $error("open-drain bit drives high");

endmodule : sbp_pad_drive
`default_nettype wire

// >>> rtl/sbp_port.sv
// Six-bit port with direction control, AHB-Lite register slave
// Function
// - Six-bit output data latch, one per pin
// - Set direction bit tri-states the pin
// - Clear direction bit drives latch onto pin
// - Data read returns pins; write updates latch
// - Set and clear writes are read-modify-write of pin levels
// - Bit 4 open-drain, Schmitt; others push-pull
// - Bit 4 feeds timer zero external clock
// - Bits 0-3, 5 selectable as analog inputs
// - Bit 3 selectable as analog reference input
// - Bit 5 feeds serial port slave select
// - After reset, analog pins read zero
// - Enabled alternate function removes pin from GPIO
`timescale 1ns/1ns
`default_nettype none
module sbp_port
   import sbp_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [11:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic [5:0]  pin_in,
   output logic [5:0]       pin_out,
   output logic [5:0]       pin_oe,
   input  wire logic        timer_clk_enable,
   input  wire logic        slave_select_enable,
   output logic             timer_zero_external_clock,
   output logic             slave_select_in,
   output logic [5:0]       analog_enable,
   output logic             vref_enable
);

   sbp_drive_if #(.W(SBP_W)) dif ();

   logic [SBP_W-1:0]      latch;
   logic [SBP_W-1:0]      dir;
   logic [SBP_ACFG_W-1:0] acfg;
   logic [SBP_W-1:0]      pin_sample;
   logic [SBP_W-1:0]      pin_read;
   logic [SBP_W-1:0]      next_latch;
   logic [SBP_W-1:0]      next_dir;
   logic [SBP_ACFG_W-1:0] next_acfg;
   logic [31:0]           next_rdata;
   logic                  addr_valid;
   sbp_acc_t              addr_acc;
   sbp_acc_t              wr_acc;
   sbp_acc_t              rd_acc;

   // Address phase
   assign addr_valid = hsel && hready && (htrans == HTRANS_NONSEQ
                       || htrans == 2'h3);
   assign addr_acc   = sbp_decode(haddr);

   // Only whole-word transfers are issued; hsize is not checked
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_acc <= ACC_NONE;
         rd_acc <= ACC_NONE;
      end else begin
         wr_acc <= (addr_valid && hwrite) ? addr_acc : ACC_NONE;
         rd_acc <= (addr_valid && !hwrite) ? addr_acc : ACC_NONE;
      end
   end

   // Zero wait states, always OKAY
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // Pins are synchronous; one register stage to the read path
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_sample <= LATCH_RST;
      end else begin
         pin_sample <= pin_in;
      end
   end

   // Analog-selected pins read as zero on the digital path
   assign pin_read = pin_sample & ~analog_enable;

   // Data-phase writes; set and clear writes use registered pin levels
   always_comb begin
      next_latch = latch;
      next_dir   = dir;
      next_acfg  = acfg;
      case (wr_acc)
         ACC_DATA: begin
            next_latch = hwdata[SBP_W-1:0];
         end
         ACC_SET: begin
            next_latch = pin_read | hwdata[SBP_W-1:0];
         end
         ACC_CLR: begin
            next_latch = pin_read & ~hwdata[SBP_W-1:0];
         end
         ACC_DIR: begin
            next_dir = hwdata[SBP_W-1:0];
         end
         ACC_ACFG: begin
            next_acfg = hwdata[SBP_ACFG_W-1:0];
         end
         default: begin
            next_latch = latch;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         latch <= LATCH_RST;
      end else begin
         latch <= next_latch;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dir <= DIR_RST;
      end else begin
         dir <= next_dir;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         acfg <= ACFG_RST;
      end else begin
         acfg <= next_acfg;
      end
   end

   // Read mux uses next register values so a read right after a write is fresh; data reads return sampled pins
   always_comb begin
      next_rdata = RD_ZERO;
      case (addr_acc)
         ACC_DATA: next_rdata[SBP_W-1:0] = pin_read;
         ACC_DIR:  next_rdata[SBP_W-1:0] = next_dir;
         ACC_ACFG: next_rdata[SBP_ACFG_W-1:0] = next_acfg;
         ACC_SET:  next_rdata[SBP_W-1:0] = next_latch;
         ACC_CLR:  next_rdata[SBP_W-1:0] = next_latch;
         default:  next_rdata = RD_ZERO;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= RD_ZERO;
      end else if (addr_valid && !hwrite) begin
         hrdata <= next_rdata;
      end else begin
         hrdata <= RD_ZERO;
      end
   end

   // Analog routing follows the configuration register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         analog_enable <= ANA_ALL;
         vref_enable   <= 1'b0;
      end else begin
         analog_enable <= sbp_ana_mask(acfg);
         vref_enable   <= acfg[0] && (sbp_ana_mask(acfg) != ANA_NONE);
      end
   end

   // Alternate inputs always see the pin; Schmitt input is in the pad
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         timer_zero_external_clock <= 1'b0;
         slave_select_in           <= 1'b0;
      end else begin
         timer_zero_external_clock <= pin_in[OD_BIT];
         slave_select_in           <= pin_in[SS_BIT];
      end
   end

   // Direction still acts in analog mode; software keeps it set
   assign dif.latch   = latch;
   assign dif.dir     = dir;
   assign dif.hold_in = (timer_clk_enable ? OD_MASK : LATCH_RST)
                      | (slave_select_enable ? SS_MASK : LATCH_RST);

   sbp_pad_drive u_pad (
      .hclk    (hclk),
      .hresetn (hresetn),
      .dif     (dif)
   );

   assign pin_out = dif.pad_out;
   assign pin_oe  = dif.pad_oe;

   chk_read_upper: assert property (@(posedge hclk)
      disable iff (!hresetn)
      (rd_acc == ACC_DATA || rd_acc == ACC_DIR) |-> hrdata[31:6] == 26'h0)
      else $error("unimplemented port bits read nonzero");

   chk_data_read: assert property (@(posedge hclk)
      disable iff (!hresetn)
      (rd_acc == ACC_DATA) |->
         hrdata[5:0] == ($past(pin_sample) & ~$past(analog_enable)))
      else $error("data read does not return pin levels");

   chk_data_write: assert property (@(posedge hclk)
      disable iff (!hresetn)
      (wr_acc == ACC_DATA) |=> latch == $past(hwdata[5:0]) ##1
         (pin_out[0] == latch[0] || dir[0] || pin_oe[0] == 1'b0))
      else $error("data write did not reach the latch");

   chk_rmw_set: assert property (@(posedge hclk)
      disable iff (!hresetn)
      (wr_acc == ACC_SET) |=>
         latch == ($past(pin_read) | $past(hwdata[5:0])))
      else $error("set write is not read-modify-write");

   chk_rmw_clear: assert property (@(posedge hclk)
      disable iff (!hresetn)
      (wr_acc == ACC_CLR) |=>
         latch == ($past(pin_read) & ~$past(hwdata[5:0])))
      else $error("clear write is not read-modify-write");

   chk_analog_zero: assert property (@(posedge hclk)
      disable iff (!hresetn)
      (rd_acc == ACC_DATA) |->
         (hrdata[5:0] & $past(analog_enable)) == 6'h00)
      else $error("analog pin reads nonzero");

   chk_analog_map: assert property (@(posedge hclk)
      disable iff (!hresetn)
      (acfg == 3'h0) |=> analog_enable == 6'h2F)
      else $error("analog selection wrong for code zero");

   chk_vref_pin: assert property (@(posedge hclk)
      disable iff (!hresetn)
      vref_enable |-> analog_enable[VREF_BIT] && $past(acfg[0]))
      else $error("reference on a non-analog pin");

   chk_timer_clk: assert property (@(posedge hclk)
      disable iff (!hresetn)
      timer_zero_external_clock == pin_sample[OD_BIT])
      else $error("timer clock not following bit 4 pin");

   chk_slave_sel: assert property (@(posedge hclk)
      disable iff (!hresetn)
      slave_select_in == pin_sample[SS_BIT])
      else $error("slave select not following bit 5 pin");

   chk_alt_hold: assert property (@(posedge hclk)
      disable iff (!hresetn)
      (slave_select_enable && timer_clk_enable) |=>
         !pin_oe[SS_BIT] && !pin_oe[OD_BIT])
      else $error("pin driven while alternate function enabled");

   chk_latch_drive: assert property (@(posedge hclk)
      disable iff (!hresetn)
      (!dir[1] && wr_acc == ACC_DATA) |=> ##1
         (pin_oe[1] || dir[1]) && pin_out[1] == $past(latch[1]))
      else $error("latched value not driven on output pin");

   // Bus side: fixed answer, read data only in its data phase
   chk_bus_okay: assert property (@(posedge hclk)
      disable iff (!hresetn)
      hreadyout && !hresp)
      else $error("bus answer not ready and okay");

   chk_read_idle: assert property (@(posedge hclk)
      disable iff (!hresetn)
      !(addr_valid && !hwrite) |=> hrdata == RD_ZERO)
      else $error("read data outside its data phase");

   chk_data_only: assert property (@(posedge hclk)
      disable iff (!hresetn)
      (wr_acc == ACC_DATA) |=> $stable(dir) && $stable(acfg))
      else $error("data write touched other registers");

   chk_dir_write: assert property (@(posedge hclk)
      disable iff (!hresetn)
      (wr_acc == ACC_DIR) |=> dir == $past(hwdata[5:0]))
      else $error("direction write did not land");

   chk_acfg_write: assert property (@(posedge hclk)
      disable iff (!hresetn)
      (wr_acc == ACC_ACFG) |=> acfg == $past(hwdata[2:0]))
      else $error("analog configuration write did not land");

   // Routing follows the configuration one cycle late
   chk_analog_low4: assert property (@(posedge hclk)
      disable iff (!hresetn)
      (acfg[2:1] == 2'h1) |=> analog_enable == ANA_LOW4)
      else $error("analog selection wrong for code one");

   chk_analog_low3: assert property (@(posedge hclk)
      disable iff (!hresetn)
      (acfg[2:1] == 2'h2) |=> analog_enable == ANA_LOW3)
      else $error("analog selection wrong for code two");

   chk_analog_none: assert property (@(posedge hclk)
      disable iff (!hresetn)
      (acfg[2:1] == 2'h3) |=> analog_enable == ANA_NONE)
      else $error("analog selection wrong for digital code");

   chk_vref_on: assert property (@(posedge hclk)
      disable iff (!hresetn)
      (acfg[0] && acfg[2:1] != 2'h3) |=> vref_enable)
      else $error("reference input not selected");

   // Pin release under alternate functions and open drain
   chk_timer_release: assert property (@(posedge hclk)
      disable iff (!hresetn)
      timer_clk_enable |=> !pin_oe[OD_BIT])
      else $error("timer clock pin driven while in use");

   chk_ss_release: assert property (@(posedge hclk)
      disable iff (!hresetn)
      slave_select_enable |=> !pin_oe[SS_BIT])
      else $error("slave select pin driven while in use");

   chk_od_release: assert property (@(posedge hclk)
      disable iff (!hresetn)
      latch[OD_BIT] |=> !pin_oe[OD_BIT])
      else $error("open-drain pin driven for a high level");

endmodule : sbp_port
`default_nettype wire

// >>> verif/sbp_pin_model.sv
// Board-side pin model: pull-up on the open-drain pin, noise elsewhere
`timescale 1ns/1ns
`default_nettype none
module sbp_pin_model
   import sbp_pkg::*;
(
   input  wire logic       hclk,
   input  wire logic [5:0] pin_out,
   input  wire logic [5:0] pin_oe,
   input  wire logic [5:0] ext_en,
   input  wire logic [5:0] ext_val,
   output logic [5:0]      pin_in
);
   // Floating pins toggle so a stale value never looks valid
   logic [5:0] noise = 6'h15;
   always @(posedge hclk) begin
      noise <= ~noise;
   end
   always_comb begin
      for (int i = 0; i < SBP_W; i++) begin
         if (pin_oe[i]) begin
            pin_in[i] = pin_out[i];
         end else if (ext_en[i]) begin
            pin_in[i] = ext_val[i];
         end else if (i == OD_BIT) begin
            pin_in[i] = 1'b1;
         end else begin
            pin_in[i] = noise[i];
         end
      end
   end
endmodule : sbp_pin_model
`default_nettype wire

// >>> verif/six_bit_port_with_direction_control_test.sv
// Self-checking bench for the six-bit port
`timescale 1ns/1ns
`default_nettype none
module six_bit_port_with_direction_control_test
   import sbp_pkg::*;
;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [11:0] haddr = 12'h000;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h0000_0000;
   logic        hreadyout, hresp, tz_clk, ss_in, vref_en;
   logic [31:0] hrdata, rd;
   logic [5:0]  pin_in, pin_out, pin_oe, ana_en;
   logic [5:0]  ext_en = 6'h00;
   logic [5:0]  ext_val = 6'h00;
   logic        tmr_en = 1'b0;
   logic        ssp_en = 1'b0;
   int          err_total = 0;
   int          cmp_count = 0;
   int          cycles = 0;
   logic [5:0]  amask [4] = '{6'h2F, 6'h0F, 6'h0B, 6'h00};

   always #20 hclk = ~hclk;

   sbp_port dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe(pin_oe), .timer_clk_enable(tmr_en),
      .slave_select_enable(ssp_en), .timer_zero_external_clock(tz_clk),
      .slave_select_in(ss_in), .analog_enable(ana_en),
      .vref_enable(vref_en));

   sbp_pin_model pins_u (.hclk(hclk), .pin_out(pin_out), .pin_oe(pin_oe),
      .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

   function automatic logic [11:0] adr(input logic [7:0] idx);
      return {2'b00, idx, 2'b00};
   endfunction : adr

   task automatic complete_run;
      if (err_total == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : complete_run

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         err_total++;
      end
   endtask : chk

   // Address phase held until hready, then data phase until hready
   task automatic bus(input logic wr, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= a;
      hwrite <= wr;
      htrans <= HTRANS_NONSEQ;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wr ? d : 32'h0000_0000;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      q = hrdata;
   endtask : bus

   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      bus(1'b1, adr(idx), d, rd);
   endtask : wr

   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000, rd);
      chk(rd, exp);
      chk({31'h0, hresp}, 32'h0000_0000);
   endtask : rdchk

   // Pins follow a register change one cycle later; allow for it
   task automatic settle;
      repeat (2) @(posedge hclk);
      @(negedge hclk);
   endtask : settle

   always @(posedge hclk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         err_total++;
         complete_run();
      end
   end

   initial begin
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(negedge hclk);
      chk({26'h0, ana_en}, {26'h0, ANA_ALL});
      chk({31'h0, vref_en}, 32'h0000_0000);
      chk({26'h0, pin_oe}, 32'h0000_0000);
      rdchk(adr(IDX_DIR), {26'h0, DIR_RST});
      rdchk(adr(IDX_DATA), {26'h0, OD_MASK});
      rdchk(adr(IDX_ACFG), {29'h0, ACFG_RST});
      // Direction stays all-input while any pin is analog
      for (int c = 0; c < 8; c++) begin
         wr(IDX_ACFG, 32'hFFFF_FFF8 | c);
         settle();
         chk({26'h0, ana_en}, {26'h0, amask[c/2]});
         chk({31'h0, vref_en}, (c % 2 == 1 && c < 6) ? 1 : 0);
      end
      wr(IDX_ACFG, 32'h0000_0006);
      rdchk(adr(IDX_ACFG), 32'h0000_0006);
      wr(IDX_DIR, 32'h0000_0000);
      settle();
      chk({26'h0, pin_oe}, 32'h0000_003F);
      chk({26'h0, pin_out}, 32'h0000_0000);
      @(posedge hclk);
      tmr_en <= 1'b1;
      ssp_en <= 1'b1;
      settle();
      chk({26'h0, pin_oe}, 32'h0000_000F);
      @(posedge hclk);
      tmr_en <= 1'b0;
      ssp_en <= 1'b0;
      wr(IDX_DATA, 32'hFFFF_FFFA);
      settle();
      chk({26'h0, pin_oe}, 32'h0000_002F);
      chk({26'h0, pin_out}, 32'h0000_002A);
      rdchk(adr(IDX_DATA), 32'h0000_003A);
      wr(IDX_DIR, 32'hFFFF_FFFF);
      rdchk(adr(IDX_DIR), 32'h0000_003F);
      ext_en  <= 6'h3F;
      ext_val <= 6'h15;
      settle();
      chk({26'h0, pin_oe}, 32'h0000_0000);
      chk({30'h0, tz_clk, ss_in}, 32'h0000_0002);
      rdchk(adr(IDX_DATA), 32'h0000_0015);
      wr(IDX_SET, 32'h0000_0002);
      rdchk(adr(IDX_SET), 32'h0000_0017);
      wr(IDX_CLR, 32'h0000_0004);
      rdchk(adr(IDX_CLR), 32'h0000_0011);
      ext_val <= 6'h2A;
      settle();
      chk({30'h0, tz_clk, ss_in}, 32'h0000_0001);
      rdchk(12'h100, 32'h0000_0000);
      complete_run();
   end
endmodule : six_bit_port_with_direction_control_test
`default_nettype wire
